// File: core/rail_pkg.sv
package rail_pkg;

   // ==========================================
   // register map
   localparam logic [7:0] ENABLE_SETUP_ADDR = 8'h08;
   localparam logic [7:0] LIMIT_SLEW_ADDR = 8'h09;
   localparam logic [7:0] VOLTAGE_CODE_ADDR = 8'h0a;
   localparam logic [7:0] LOW_VOLTAGE_CODE_ADDR = 8'h0b;

   // ==========================================
   // values after reset
   localparam logic [7:0] ENABLE_SETUP_RESET = 8'hc8;
   localparam logic [7:0] LIMIT_SLEW_RESET = 8'h32;
   localparam logic [7:0] VOLTAGE_CODE_RESET = 8'h4d;
   localparam logic [7:0] LOW_VOLTAGE_CODE_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // ==========================================
   // field positions in the enable/setup register
   localparam int RAIL3_ON_BIT = 7;
   localparam int RAIL3_PIN_GATING_BIT = 6;
   localparam int RAIL3_PIN_CHOICE_BIT = 5;
   localparam int RAIL3_PIN_LEVEL_MODE_BIT = 4;
   localparam int RAIL3_DISCHARGE_ON_BIT = 3;
   localparam int RAIL3_FIXED_PULSE_WIDTH_BIT = 1;

   // field positions in the limit/slew register
   localparam int RAIL3_CURRENT_LIMIT_LSB = 3;
   localparam int RAIL3_RAMP_RATE_LSB = 0;
   localparam int FIELD3_WIDTH = 3;

   // ==========================================
   // voltage code map, in microvolts
   localparam int VOLT_UV_WIDTH = 22;
   localparam logic [7:0] CODE_FINE_FIRST = 8'h18;
   localparam logic [7:0] CODE_COARSE_FIRST = 8'h9e;
   localparam int LOW_BASE_UV = 500000;
   localparam int LOW_STEP_UV = 10000;
   localparam int FINE_BASE_UV = 735000;
   localparam int FINE_STEP_UV = 5000;
   localparam int COARSE_BASE_UV = 1420000;
   localparam int COARSE_STEP_UV = 20000;

   function automatic logic [VOLT_UV_WIDTH-1:0] code_to_uv(input logic [7:0] code);
      int uv;
      uv = 0;
      if (code < CODE_FINE_FIRST) begin
         uv = LOW_BASE_UV + int'(code) * LOW_STEP_UV;
      end else if (code < CODE_COARSE_FIRST) begin
         uv = FINE_BASE_UV + int'(code - CODE_FINE_FIRST) * FINE_STEP_UV;
      end else begin
         uv = COARSE_BASE_UV + int'(code - CODE_COARSE_FIRST) * COARSE_STEP_UV;
      end
      return uv[VOLT_UV_WIDTH-1:0];
   endfunction

   localparam logic [VOLT_UV_WIDTH-1:0] VOLTAGE_RESET_UV = 22'h0f4240;

   // ==========================================
   // slew rates, microvolts per microsecond, and per-cycle steps
   localparam int CLK_MHZ = 50;
   localparam int RATE0_UV_PER_US = 30000;
   localparam int RATE1_UV_PER_US = 15000;
   localparam int RATE2_UV_PER_US = 10000;
   localparam int RATE3_UV_PER_US = 7500;
   localparam int RATE4_UV_PER_US = 3800;
   localparam int RATE5_UV_PER_US = 1900;
   localparam int RATE6_UV_PER_US = 940;
   localparam int RATE7_UV_PER_US = 400;
   localparam int STEP_WIDTH = 10;

   // longest-time rounding: step rounds down, never below one
   function automatic logic [STEP_WIDTH-1:0] rate_step(input int rate_uv_per_us);
      int s;
      s = rate_uv_per_us / CLK_MHZ;
      if (s < 1) begin
         s = 1;
      end
      return s[STEP_WIDTH-1:0];
   endfunction

   function automatic logic [STEP_WIDTH-1:0] slew_step(input logic [2:0] code);
      logic [STEP_WIDTH-1:0] s;
      s = '0;
      case (code)
         3'h0: s = rate_step(RATE0_UV_PER_US);
         3'h1: s = rate_step(RATE1_UV_PER_US);
         3'h2: s = rate_step(RATE2_UV_PER_US);
         3'h3: s = rate_step(RATE3_UV_PER_US);
         3'h4: s = rate_step(RATE4_UV_PER_US);
         3'h5: s = rate_step(RATE5_UV_PER_US);
         3'h6: s = rate_step(RATE6_UV_PER_US);
         default: s = rate_step(RATE7_UV_PER_US);
      endcase
      return s;
   endfunction

endpackage

// File: core/ramp_if.sv
`timescale 1ns/1ps
interface ramp_if;
   logic [rail_pkg::VOLT_UV_WIDTH-1:0] target_uv;
   logic [2:0] ramp_rate;
   logic [rail_pkg::VOLT_UV_WIDTH-1:0] level_uv;
   logic moving;

   modport ctrl (output target_uv, output ramp_rate, input level_uv, input moving);
   modport ramp (input target_uv, input ramp_rate, output level_uv, output moving);
endinterface

// File: core/rail_ramp.sv
`timescale 1ns/1ps
module rail_ramp (
   // clock and reset
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   // target and present level
   ramp_if.ramp rp
);

   // ==========================================
   // level walks toward target by a fixed step per cycle
   logic [rail_pkg::VOLT_UV_WIDTH-1:0] level_reg;
   logic [rail_pkg::VOLT_UV_WIDTH-1:0] level_next;
   logic moving_reg;
   logic moving_next;

   // overshoot is clamped so the level lands exactly on target
   always_comb begin
      logic [rail_pkg::VOLT_UV_WIDTH-1:0] step;
      step = rail_pkg::VOLT_UV_WIDTH'(rail_pkg::slew_step(rp.ramp_rate));
      level_next = level_reg;
      if (level_reg < rp.target_uv) begin
         if (rp.target_uv - level_reg > step) begin
            level_next = level_reg + step;
         end else begin
            level_next = rp.target_uv;
         end
      end else if (level_reg > rp.target_uv) begin
         if (level_reg - rp.target_uv > step) begin
            level_next = level_reg - step;
         end else begin
            level_next = rp.target_uv;
         end
      end
      moving_next = (level_next != rp.target_uv);
   end

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         level_reg <= rail_pkg::VOLTAGE_RESET_UV;
         moving_reg <= 1'b0;
      end else begin
         level_reg <= level_next;
         moving_reg <= moving_next;
      end
   end

   assign rp.level_uv = level_reg;
   assign rp.moving = moving_reg;

endmodule

// File: core/buck_rail_control_regs.sv
// What this block does
// - rail 3 runs when its on bit is 1, stops when 0.
// - pin gating 0: on bit alone; 1: on bit AND chosen pin.
// - pin choice bit picks enable pin a (0) or b (1).
// - pin level mode 0: pin enables; 1: pin ignored, on bit alone runs rail 3.
// - discharge bit 1 connects discharge resistor while rail 3 is off.
// - fixed pulse width bit forces PWM; 0 lets mode change automatically.
// - current limit field bits 5:3, codes 2..7 map 2.5 A to 5.0 A.
// - ramp rate field bits 2:0 sets rise and fall slew, eight rates.
// - codes 0x00..0x17 give 0.5 V to 0.73 V in 10 mV steps.
// - codes 0x18..0x9d give 0.735 V to 1.4 V in 5 mV steps.
// - codes 0x9e..0xff give 1.42 V to 3.36 V in 20 mV steps.
// - rail 0 target code resets to 0x4d, i.e. 1000 mV.
// - low state code, reset 0x00, sets rail 0 when low state selected.
`timescale 1ns/1ps
module buck_rail_control_regs (
   // clock and reset
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   // register port from the serial engine
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_write_in,
   input wire logic reg_read_in,
   output logic [7:0] reg_rdata_out,
   // external pins
   input wire logic enable_pin_a_in,
   input wire logic enable_pin_b_in,
   input wire logic rail0_low_state_in,
   // rail 3 controls
   output logic rail3_run_out,
   output logic rail3_discharge_out,
   output logic rail3_fixed_pulse_width_out,
   output logic [2:0] rail3_current_limit_out,
   output logic [2:0] rail3_ramp_rate_out,
   // rail 0 output level
   output logic [rail_pkg::VOLT_UV_WIDTH-1:0] rail0_level_uv_out,
   output logic rail0_ramping_out
);

   // ==========================================
   // pin synchronisers
   logic [2:0] pin_meta_reg;
   logic [2:0] pin_sync_reg;

   // first stage feeds only the second stage
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         pin_meta_reg <= 3'h0;
         pin_sync_reg <= 3'h0;
      end else begin
         pin_meta_reg <= {rail0_low_state_in, enable_pin_b_in, enable_pin_a_in};
         pin_sync_reg <= pin_meta_reg;
      end
   end

   // ==========================================
   // register file
   logic [7:0] enable_setup_reg;
   logic [7:0] enable_setup_next;
   logic [7:0] limit_slew_reg;
   logic [7:0] limit_slew_next;
   logic [7:0] voltage_code_reg;
   logic [7:0] voltage_code_next;
   logic [7:0] low_voltage_code_reg;
   logic [7:0] low_voltage_code_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;

   // all bits stored as written, reserved ones too; unmapped writes dropped
   always_comb begin
      enable_setup_next = enable_setup_reg;
      limit_slew_next = limit_slew_reg;
      voltage_code_next = voltage_code_reg;
      low_voltage_code_next = low_voltage_code_reg;
      if (reg_write_in) begin
         case (reg_addr_in)
            rail_pkg::ENABLE_SETUP_ADDR: enable_setup_next = reg_wdata_in;
            rail_pkg::LIMIT_SLEW_ADDR: limit_slew_next = reg_wdata_in;
            rail_pkg::VOLTAGE_CODE_ADDR: voltage_code_next = reg_wdata_in;
            rail_pkg::LOW_VOLTAGE_CODE_ADDR: low_voltage_code_next = reg_wdata_in;
            default: enable_setup_next = enable_setup_reg;
         endcase
      end
   end

   // read data is registered: valid the cycle after the read strobe
   always_comb begin
      rdata_next = rdata_reg;
      if (reg_read_in) begin
         case (reg_addr_in)
            rail_pkg::ENABLE_SETUP_ADDR: rdata_next = enable_setup_reg;
            rail_pkg::LIMIT_SLEW_ADDR: rdata_next = limit_slew_reg;
            rail_pkg::VOLTAGE_CODE_ADDR: rdata_next = voltage_code_reg;
            rail_pkg::LOW_VOLTAGE_CODE_ADDR: rdata_next = low_voltage_code_reg;
            default: rdata_next = rail_pkg::UNMAPPED_READ;
         endcase
      end
   end

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         enable_setup_reg <= rail_pkg::ENABLE_SETUP_RESET;
         limit_slew_reg <= rail_pkg::LIMIT_SLEW_RESET;
         voltage_code_reg <= rail_pkg::VOLTAGE_CODE_RESET;
         low_voltage_code_reg <= rail_pkg::LOW_VOLTAGE_CODE_RESET;
         rdata_reg <= 8'h00;
      end else begin
         enable_setup_reg <= enable_setup_next;
         limit_slew_reg <= limit_slew_next;
         voltage_code_reg <= voltage_code_next;
         low_voltage_code_reg <= low_voltage_code_next;
         rdata_reg <= rdata_next;
      end
   end

   // ==========================================
   // rail 3 enable decision
   logic run_reg;
   logic run_next;
   logic discharge_reg;
   logic discharge_next;
   logic fpwm_reg;
   logic fpwm_next;
   logic [2:0] ilim_reg;
   logic [2:0] ilim_next;
   logic [2:0] slew_reg;
   logic [2:0] slew_next;

   // in level mode the chosen pin no longer gates the rail; only the on bit counts
   always_comb begin
      logic on_bit;
      logic pin;
      on_bit = enable_setup_reg[rail_pkg::RAIL3_ON_BIT];
      pin = enable_setup_reg[rail_pkg::RAIL3_PIN_CHOICE_BIT] ?
            pin_sync_reg[1] : pin_sync_reg[0];
      run_next = on_bit;
      if (enable_setup_reg[rail_pkg::RAIL3_PIN_GATING_BIT]) begin
         if (!enable_setup_reg[rail_pkg::RAIL3_PIN_LEVEL_MODE_BIT]) begin
            run_next = on_bit & pin;
         end
      end
      // without gating, choice and mode bits are never looked at
      discharge_next = enable_setup_reg[rail_pkg::RAIL3_DISCHARGE_ON_BIT] & ~run_next;
      fpwm_next = enable_setup_reg[rail_pkg::RAIL3_FIXED_PULSE_WIDTH_BIT];
      ilim_next = limit_slew_reg[rail_pkg::RAIL3_CURRENT_LIMIT_LSB +: rail_pkg::FIELD3_WIDTH];
      slew_next = limit_slew_reg[rail_pkg::RAIL3_RAMP_RATE_LSB +: rail_pkg::FIELD3_WIDTH];
   end

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         run_reg <= 1'b0;
         discharge_reg <= 1'b0;
         fpwm_reg <= 1'b0;
         ilim_reg <= 3'h0;
         slew_reg <= 3'h0;
      end else begin
         run_reg <= run_next;
         discharge_reg <= discharge_next;
         fpwm_reg <= fpwm_next;
         ilim_reg <= ilim_next;
         slew_reg <= slew_next;
      end
   end

   // ==========================================
   // rail 0 target selection and ramp
   logic [rail_pkg::VOLT_UV_WIDTH-1:0] target_reg;
   logic [rail_pkg::VOLT_UV_WIDTH-1:0] target_next;
   logic [rail_pkg::VOLT_UV_WIDTH-1:0] level_out_reg;
   logic ramping_reg;
   ramp_if rail0_rp ();

   // code map covers all three segments in one lookup
   always_comb begin
      logic [7:0] code;
      code = pin_sync_reg[2] ? low_voltage_code_reg : voltage_code_reg;
      target_next = rail_pkg::code_to_uv(code);
   end

   // rail 0 shares the rail 3 ramp rate, the only one held here
   assign rail0_rp.target_uv = target_reg;
   assign rail0_rp.ramp_rate = slew_reg;

   rail_ramp rail0_ramp (
      .mclk_in(mclk_in),
      .sys_rst_in(sys_rst_in),
      .rp(rail0_rp.ramp)
   );

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         target_reg <= rail_pkg::VOLTAGE_RESET_UV;
         level_out_reg <= rail_pkg::VOLTAGE_RESET_UV;
         ramping_reg <= 1'b0;
      end else begin
         target_reg <= target_next;
         level_out_reg <= rail0_rp.level_uv;
         ramping_reg <= rail0_rp.moving;
      end
   end

   // ==========================================
   // outputs, all straight from flip-flops
   assign reg_rdata_out = rdata_reg;
   assign rail3_run_out = run_reg;
   assign rail3_discharge_out = discharge_reg;
   assign rail3_fixed_pulse_width_out = fpwm_reg;
   assign rail3_current_limit_out = ilim_reg;
   assign rail3_ramp_rate_out = slew_reg;
   assign rail0_level_uv_out = level_out_reg;
   assign rail0_ramping_out = ramping_reg;

endmodule

// File: verif/rail_ctrl_properties.sv
`timescale 1ns/1ps
// ==========================================
// rail control checker
module rail_ctrl_properties (
   // clock and reset
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   // register port
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_write_in,
   input wire logic reg_read_in,
   input wire logic [7:0] reg_rdata_out,
   // rail outputs
   input wire logic rail3_run_out,
   input wire logic rail3_discharge_out,
   input wire logic rail3_fixed_pulse_width_out,
   input wire logic [2:0] rail3_current_limit_out,
   input wire logic [2:0] rail3_ramp_rate_out,
   input wire logic [rail_pkg::VOLT_UV_WIDTH-1:0] rail0_level_uv_out
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (sys_rst_in);

   // write decodes, so the properties stay short
   wire logic wr_setup = reg_write_in && reg_addr_in == 8'h08;
   wire logic wr_limit = reg_write_in && reg_addr_in == 8'h09;

   // ==========================================
   // register to output paths
   a_limit_tracks: assert property (
      wr_limit |-> ##2 rail3_current_limit_out == $past(reg_wdata_in[5:3], 2))
      else $error("current limit not taken from write");
   a_rate_tracks: assert property (
      wr_limit |-> ##2 rail3_ramp_rate_out == $past(reg_wdata_in[2:0], 2))
      else $error("ramp rate not taken from write");
   a_read_back: assert property (
      reg_read_in && reg_addr_in == 8'h09 && !reg_write_in && !$past(reg_write_in)
      && !$past(sys_rst_in) |=> reg_rdata_out[5:0] ==
      {$past(rail3_current_limit_out), $past(rail3_ramp_rate_out)})
      else $error("limit register read differs from outputs");
   a_off_stops: assert property (
      wr_setup && !reg_wdata_in[7] ##1 !wr_setup |-> ##1 !rail3_run_out)
      else $error("rail runs with on bit clear");
   a_ungated_runs: assert property (
      wr_setup && reg_wdata_in[7:6] == 2'b10 ##1 !wr_setup |-> ##1 rail3_run_out)
      else $error("rail stopped without pin gating");
   a_pwm_tracks: assert property (
      wr_setup |-> ##2 rail3_fixed_pulse_width_out == $past(reg_wdata_in[1], 2))
      else $error("fixed pulse width not taken from write");
   a_discharge_off: assert property (
      wr_setup && !reg_wdata_in[3] ##1 !wr_setup |-> ##1 !rail3_discharge_out)
      else $error("discharge on with bit clear");
   a_discharge_idle: assert property (
      rail3_discharge_out |-> !rail3_run_out)
      else $error("discharge while running");
   // a single cycle never moves more than the fastest step
   a_level_step: assert property (
      !$past(sys_rst_in) |-> (rail0_level_uv_out - $past(rail0_level_uv_out) <= 22'h258)
      || ($past(rail0_level_uv_out) - rail0_level_uv_out <= 22'h258))
      else $error("level stepped faster than ramp");
endmodule

bind buck_rail_control_regs rail_ctrl_properties i_props (
   .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
   .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
   .reg_rdata_out(reg_rdata_out), .rail3_run_out(rail3_run_out),
   .rail3_discharge_out(rail3_discharge_out),
   .rail3_fixed_pulse_width_out(rail3_fixed_pulse_width_out),
   .rail3_current_limit_out(rail3_current_limit_out),
   .rail3_ramp_rate_out(rail3_ramp_rate_out), .rail0_level_uv_out(rail0_level_uv_out));

// File: verif/buck_rail_control_regs_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; \
   $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
module buck_rail_control_regs_tb;
   // ==========================================
   // stimulus and observed signals
   logic mclk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic [7:0] reg_addr_in = 8'h00;
   logic [7:0] reg_wdata_in = 8'h00;
   logic reg_write_in = 1'b0;
   logic reg_read_in = 1'b0;
   logic enable_pin_a_in = 1'b0;
   logic enable_pin_b_in = 1'b0;
   logic rail0_low_state_in = 1'b0;
   logic [7:0] reg_rdata_out, v;
   logic rail3_run_out, rail3_discharge_out, rail3_fixed_pulse_width_out, rail0_ramping_out;
   logic [2:0] rail3_current_limit_out, rail3_ramp_rate_out;
   logic [rail_pkg::VOLT_UV_WIDTH-1:0] rail0_level_uv_out;
   logic exp_run;
   logic [7:0] codes [6] = '{8'h17, 8'h18, 8'h9d, 8'h9e, 8'hff, 8'h00};
   int fails = 0;
   int n_checks = 0;

   // 50 MHz clock
   always #10 mclk_in = ~mclk_in;

   buck_rail_control_regs i_dut (
      .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
      .reg_rdata_out(reg_rdata_out), .enable_pin_a_in(enable_pin_a_in),
      .enable_pin_b_in(enable_pin_b_in), .rail0_low_state_in(rail0_low_state_in),
      .rail3_run_out(rail3_run_out), .rail3_discharge_out(rail3_discharge_out),
      .rail3_fixed_pulse_width_out(rail3_fixed_pulse_width_out),
      .rail3_current_limit_out(rail3_current_limit_out),
      .rail3_ramp_rate_out(rail3_ramp_rate_out), .rail0_level_uv_out(rail0_level_uv_out),
      .rail0_ramping_out(rail0_ramping_out));

   // ==========================================
   // register access, one-cycle strobes
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_write_in <= 1'b1;
      @(posedge mclk_in);
      reg_write_in <= 1'b0;
   endtask

   // read data lands one edge after the read is taken
   task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk_in);
      reg_addr_in <= a;
      reg_read_in <= 1'b1;
      @(posedge mclk_in);
      reg_read_in <= 1'b0;
      @(posedge mclk_in);
      #1;
      `CHK(reg_rdata_out, e)
   endtask

   // target in microvolts, worked out independently of the design
   function automatic int uv(input logic [7:0] c);
      if (c < 8'h18) begin
         return 500000 + int'(c) * 10000;
      end
      if (c < 8'h9e) begin
         return 735000 + int'(c - 8'h18) * 5000;
      end
      return 1420000 + int'(c - 8'h9e) * 20000;
   endfunction

   // a jump must not land at once, then settle within a bounded wait;
   // six edges cover the pin path, which is two edges longer than a write
   task automatic settle(input int e);
      repeat (6) @(posedge mclk_in);
      #1;
      `CHK(rail0_level_uv_out == e, 1'b0)
      `CHK(rail0_ramping_out, 1'b1)
      for (int k = 0; k < 6000 && rail0_ramping_out !== 1'b0; k++) begin
         @(posedge mclk_in);
         #1;
      end
      repeat (2) @(posedge mclk_in);
      #1;
      `CHK(rail0_level_uv_out, e)
      `CHK(rail0_ramping_out, 1'b0)
   endtask

   task automatic results;
      if (fails == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // watchdog, about twice the length of the full ramp sequence
   initial begin
      #600_000;
      fails++;
      results();
   end

   // ==========================================
   // test sequence
   initial begin
      repeat (2) @(posedge mclk_in);
      sys_rst_in <= 1'b0;
      chk_rd(8'h08, 8'hc8);
      chk_rd(8'h09, 8'h32);
      chk_rd(8'h0a, 8'h4d);
      chk_rd(8'h0b, 8'h00);
      `CHK(rail0_level_uv_out, 22'h0f4240)
      `CHK(rail3_current_limit_out, 3'h6)
      wr(8'h0c, 8'ha5);
      chk_rd(8'h0c, 8'h00);
      // every limit and slew code, reserved bits toggled
      for (int i = 0; i < 8; i++) begin
         v = {i[1:0], i[2:0], 3'(7 - i)};
         wr(8'h09, v);
         chk_rd(8'h09, v);
         `CHK(rail3_current_limit_out, i[2:0])
         `CHK(rail3_ramp_rate_out, 3'(7 - i))
      end
      // all gating, choice, mode and pin combinations
      for (int i = 0; i < 64; i++) begin
         v = {i[0], i[1], i[2], i[3], i[1] ^ i[2], i[5], i[3] ^ i[4], i[4]};
         wr(8'h08, v);
         enable_pin_a_in <= i[4];
         enable_pin_b_in <= i[5];
         exp_run = i[0] & (!i[1] | i[3] | (i[2] ? i[5] : i[4]));
         chk_rd(8'h08, v);
         repeat (3) @(posedge mclk_in);
         #1;
         `CHK(rail3_run_out, exp_run)
         `CHK(rail3_discharge_out, (i[1] ^ i[2]) & !exp_run)
         `CHK(rail3_fixed_pulse_width_out, i[3] ^ i[4])
      end
      // fastest slew, then code range boundaries
      wr(8'h09, 8'h30);
      for (int i = 0; i < 6; i++) begin
         wr(8'h0a, codes[i]);
         settle(uv(codes[i]));
      end
      wr(8'h0b, 8'h9e);
      @(posedge mclk_in);
      rail0_low_state_in <= 1'b1;
      settle(uv(8'h9e));
      @(posedge mclk_in);
      rail0_low_state_in <= 1'b0;
      settle(uv(8'h00));
      // slowest slew: 8 uV a cycle, so a 10 mV step is still far off after 300
      wr(8'h09, 8'h37);
      wr(8'h0a, 8'h01);
      repeat (300) @(posedge mclk_in);
      #1;
      `CHK(rail0_level_uv_out < uv(8'h01), 1'b1)
      settle(uv(8'h01));
      results();
   end
endmodule
